// [pao_pkg.sv]
// shared constants for the port A/B override block
package pao_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_MCU_CONTROL = 8'h00;
	localparam logic [7:0] OFS_PORTA_OUT = 8'h04;
	localparam logic [7:0] OFS_PORTA_DIR = 8'h08;
	localparam logic [7:0] OFS_PORTA_PIN = 8'h0C;
	localparam logic [7:0] OFS_PORTB_OUT = 8'h10;
	localparam logic [7:0] OFS_PORTB_DIR = 8'h14;
	localparam logic [7:0] OFS_PORTB_PIN = 8'h18;

	// ------------------------------------------------------------
	// mcu_control fields and reset values
	// ------------------------------------------------------------
	localparam int BIT_SCAN_PORT_DISABLE = 7;
	localparam int BIT_PULLUP_GLOBAL_DISABLE = 4;
	localparam int BIT_VECTOR_TABLE_SELECT = 1;
	localparam int BIT_VECTOR_CHANGE_ENABLE = 0;
	localparam logic [7:0] MCU_CONTROL_WMASK = 8'h93;
	localparam logic [7:0] MCU_CONTROL_RESET = 8'h00;
	localparam logic [7:0] PORT_RESET = 8'h00;

	// ------------------------------------------------------------
	// port B pin positions
	// ------------------------------------------------------------
	localparam int PB_CMP_B7 = 7;
	localparam int PB_CMP_B6 = 6;
	localparam int PB_CMP_B5 = 5;
	localparam int PB_CMP_B4 = 4;
	localparam int PB_MISO = 3;
	localparam int PB_MOSI = 2;
	localparam int PB_SCK = 1;
	localparam int PB_SS = 0;

	// ------------------------------------------------------------
	// bus encodings
	// ------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'h0;
	localparam int PORT_W = 8;
endpackage : pao_pkg

// [pao_pin_cell.sv]
// one port pin: merges register control with alternate-function overrides
`timescale 1ns/10ps
module pao_pin_cell (
	input wire logic pin_direction_bit,
	input wire logic pin_output_bit,
	input wire logic pullup_global_disable,
	input wire logic pullup_ovr_en,
	input wire logic pullup_ovr_val,
	input wire logic dir_ovr_en,
	input wire logic dir_ovr_val,
	input wire logic value_ovr_en,
	input wire logic value_ovr_val,
	output logic pin_out,
	output logic pin_oe_n,
	output logic pullup_en
);
	logic drive_en;
	logic pullup_plain;

	// pull-up only for input with output bit high and no global disable
	assign pullup_plain = ({pin_direction_bit, pin_output_bit, pullup_global_disable} == 3'h2);
	assign pullup_en = pullup_ovr_en ? pullup_ovr_val : pullup_plain; // see R14 R1
	assign drive_en = dir_ovr_en ? dir_ovr_val : pin_direction_bit; // see R15
	assign pin_oe_n = ~drive_en;
	// value override only matters while the driver is on
	assign pin_out = (drive_en && value_ovr_en) ? value_ovr_val : pin_output_bit; // see R15
endmodule : pao_pin_cell

// [pao_port_ab.sv]
// port A/B pin override block with AHB-Lite register slave
// ------------------------------------------------------------
// What this block does
// R1: global disable turns every port pull-up off
// R2: port A carries address, data; pins feed data-in
// R3: port A pull-up off during address or write
// R4: port A driven on address or write phase
// R5: address qualifier marks address drive interval exactly
// R6: bit 7 outputs timer0 A or timer1 C
// R7: bits 6,5 output timer1 B and A
// R8: bit 4 outputs timer2 A when output
// R9: compare pins also carry timer PWM waveform
// R10: MISO forced input as master, direction bit as slave
// R11: MOSI forced input as slave, direction bit as master
// R12: SCK forced input as slave, direction bit as master
// R13: forced SPI inputs keep pull-up from output bit
// R14: pull-up follows 0b010 rule or override value
// R15: direction and value overrides replace register bits
// R16: SS forced input as slave, low selects slave
// R17: overrides are combinational on alternate-module state
// ------------------------------------------------------------
`timescale 1ns/10ps
module pao_port_ab (
	input wire logic clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// mcu_control side outputs
	output logic scan_port_disable,
	output logic vector_table_select,
	output logic vector_change_enable,
	// port A pads
	input wire logic [7:0] porta_pin_in,
	output logic [7:0] porta_pin_out,
	output logic [7:0] porta_pin_oe_n,
	output logic [7:0] porta_pullup_en,
	// port B pads
	input wire logic [7:0] portb_pin_in,
	output logic [7:0] portb_pin_out,
	output logic [7:0] portb_pin_oe_n,
	output logic [7:0] portb_pullup_en,
	// external memory interface
	input wire logic ext_mem_enable,
	input wire logic addr_phase_active,
	input wire logic ext_mem_wr,
	input wire logic [7:0] ext_mem_addr_lo,
	input wire logic [7:0] ext_mem_dout,
	output logic [7:0] ext_mem_din,
	// timer compare outputs and their enables
	input wire logic timer0_cmp_a_out,
	input wire logic timer0_cmp_a_en,
	input wire logic timer1_cmp_c_out,
	input wire logic timer1_cmp_c_en,
	input wire logic timer1_cmp_b_out,
	input wire logic timer1_cmp_b_en,
	input wire logic timer1_cmp_a_out,
	input wire logic timer1_cmp_a_en,
	input wire logic timer2_cmp_a_out,
	input wire logic timer2_cmp_a_en,
	input wire logic cmp_b7_timer1_sel,
	// spi
	input wire logic spi_enable_bit,
	input wire logic spi_master_select,
	input wire logic spi_slave_out,
	input wire logic spi_master_out,
	input wire logic spi_sck_out,
	output logic spi_master_in,
	output logic spi_slave_in,
	output logic spi_sck_in,
	output logic spi_slave_sel_n
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] mcu_control_q;
	logic [7:0] porta_out_q;
	logic [7:0] porta_dir_q;
	logic [7:0] portb_out_q;
	logic [7:0] portb_dir_q;
	logic [7:0] porta_meta_q;
	logic [7:0] porta_sync_q;
	logic [7:0] portb_meta_q;
	logic [7:0] portb_sync_q;
	logic pullup_global_disable;

	assign pullup_global_disable = mcu_control_q[pao_pkg::BIT_PULLUP_GLOBAL_DISABLE];
	assign scan_port_disable = mcu_control_q[pao_pkg::BIT_SCAN_PORT_DISABLE];
	assign vector_table_select = mcu_control_q[pao_pkg::BIT_VECTOR_TABLE_SELECT];
	assign vector_change_enable = mcu_control_q[pao_pkg::BIT_VECTOR_CHANGE_ENABLE];

	// ------------------------------------------------------------
	// pad input synchronisers
	// ------------------------------------------------------------
	// only the second stage feeds logic; first stage may be metastable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			porta_meta_q <= 8'h00;
			porta_sync_q <= 8'h00;
			portb_meta_q <= 8'h00;
			portb_sync_q <= 8'h00;
		end else begin
			porta_meta_q <= porta_pin_in;
			porta_sync_q <= porta_meta_q;
			portb_meta_q <= portb_pin_in;
			portb_sync_q <= portb_meta_q;
		end
	end

	// ------------------------------------------------------------
	// ahb-lite slave
	// ------------------------------------------------------------
	// zero wait state: writes land at the end of the data phase,
	// read data is registered at the address phase
	logic addr_valid;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [7:0] rd_addr;
	logic wr_mcu;
	logic wr_pa_out;
	logic wr_pa_dir;
	logic wr_pb_out;
	logic wr_pb_dir;
	logic [7:0] wbyte;

	assign addr_valid = hsel && hready
		&& (htrans == pao_pkg::HTRANS_NONSEQ || htrans == pao_pkg::HTRANS_SEQ);
	assign rd_addr = {haddr[7:2], 2'h0};
	assign wbyte = hwdata[7:0];
	assign hreadyout = 1'h1;
	assign hresp = pao_pkg::HRESP_OKAY;
	assign hrdata = rdata_q;

	assign wr_mcu = wr_pend_q && (wr_addr_q == pao_pkg::OFS_MCU_CONTROL);
	assign wr_pa_out = wr_pend_q && (wr_addr_q == pao_pkg::OFS_PORTA_OUT);
	assign wr_pa_dir = wr_pend_q && (wr_addr_q == pao_pkg::OFS_PORTA_DIR);
	assign wr_pb_out = wr_pend_q && (wr_addr_q == pao_pkg::OFS_PORTB_OUT);
	assign wr_pb_dir = wr_pend_q && (wr_addr_q == pao_pkg::OFS_PORTB_DIR);

	// unmapped addresses answer zero; unmapped and read-only addresses ignore writes
	always_comb begin
		if (rd_addr == pao_pkg::OFS_MCU_CONTROL) begin
			rdata_d = {24'h000000, mcu_control_q};
		end else if (rd_addr == pao_pkg::OFS_PORTA_OUT) begin
			rdata_d = {24'h000000, porta_out_q};
		end else if (rd_addr == pao_pkg::OFS_PORTA_DIR) begin
			rdata_d = {24'h000000, porta_dir_q};
		end else if (rd_addr == pao_pkg::OFS_PORTA_PIN) begin
			rdata_d = {24'h000000, porta_sync_q};
		end else if (rd_addr == pao_pkg::OFS_PORTB_OUT) begin
			rdata_d = {24'h000000, portb_out_q};
		end else if (rd_addr == pao_pkg::OFS_PORTB_DIR) begin
			rdata_d = {24'h000000, portb_dir_q};
		end else if (rd_addr == pao_pkg::OFS_PORTB_PIN) begin
			rdata_d = {24'h000000, portb_sync_q};
		end else begin
			rdata_d = 32'h00000000;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_q <= 1'h0;
			wr_addr_q <= 8'h00;
			rdata_q <= 32'h00000000;
		end else begin
			wr_pend_q <= addr_valid && hwrite;
			if (addr_valid) begin
				wr_addr_q <= rd_addr;
			end
			if (addr_valid && !hwrite) begin
				rdata_q <= rdata_d;
			end
		end
	end

	// reserved bits of mcu_control stay zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mcu_control_q <= pao_pkg::MCU_CONTROL_RESET;
		end else if (wr_mcu) begin
			mcu_control_q <= wbyte & pao_pkg::MCU_CONTROL_WMASK;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			porta_out_q <= pao_pkg::PORT_RESET;
			porta_dir_q <= pao_pkg::PORT_RESET;
			portb_out_q <= pao_pkg::PORT_RESET;
			portb_dir_q <= pao_pkg::PORT_RESET;
		end else begin
			if (wr_pa_out) begin
				porta_out_q <= wbyte;
			end
			if (wr_pa_dir) begin
				porta_dir_q <= wbyte;
			end
			if (wr_pb_out) begin
				portb_out_q <= wbyte;
			end
			if (wr_pb_dir) begin
				portb_dir_q <= wbyte;
			end
		end
	end

	// ------------------------------------------------------------
	// port A overrides: external memory bus
	// ------------------------------------------------------------
	// kept combinational so the pads follow the memory interface
	// in the same cycle; a registered stage would skew address/data
	logic [7:0] pa_pullup_ovr_en;
	logic [7:0] pa_pullup_ovr_val;
	logic [7:0] pa_dir_ovr_en;
	logic [7:0] pa_dir_ovr_val;
	logic [7:0] pa_value_ovr_en;
	logic [7:0] pa_value_ovr_val;
	logic pa_drive;

	// addr_phase_active is taken as given: it covers the address drive
	assign pa_drive = ext_mem_wr || addr_phase_active; // see R5
	assign pa_pullup_ovr_en = {8{ext_mem_enable && pa_drive}}; // see R3 R17
	assign pa_pullup_ovr_val = 8'h00; // see R3
	assign pa_dir_ovr_en = {8{ext_mem_enable}}; // see R4
	assign pa_dir_ovr_val = {8{pa_drive}}; // see R4
	assign pa_value_ovr_en = {8{ext_mem_enable}}; // see R4
	assign pa_value_ovr_val = (ext_mem_addr_lo & {8{addr_phase_active}})
		| (ext_mem_dout & {8{ext_mem_wr}}); // see R2 R4
	assign ext_mem_din = porta_sync_q; // see R2

	// ------------------------------------------------------------
	// port B overrides: timer compare and spi
	// ------------------------------------------------------------
	logic [7:0] pb_pullup_ovr_en;
	logic [7:0] pb_pullup_ovr_val;
	logic [7:0] pb_dir_ovr_en;
	logic [7:0] pb_dir_ovr_val;
	logic [7:0] pb_value_ovr_en;
	logic [7:0] pb_value_ovr_val;
	logic spi_as_master;
	logic spi_as_slave;
	logic b7_en;
	logic b7_val;

	assign spi_as_master = spi_enable_bit && spi_master_select;
	assign spi_as_slave = spi_enable_bit && !spi_master_select;
	// bit 7 picks one compare source; the timers present pwm on the same line
	assign b7_en = cmp_b7_timer1_sel ? timer1_cmp_c_en : timer0_cmp_a_en; // see R6 R9
	assign b7_val = cmp_b7_timer1_sel ? timer1_cmp_c_out : timer0_cmp_a_out; // see R6 R9

	// compare pins never touch direction, so the direction bit must be one
	assign pb_dir_ovr_val = 8'h00;
	assign pb_dir_ovr_en = {
		4'h0,
		spi_as_master, // see R10
		spi_as_slave, // see R11
		spi_as_slave, // see R12
		spi_as_slave // see R16
	};
	assign pb_pullup_ovr_en = pb_dir_ovr_en; // see R13
	assign pb_pullup_ovr_val = portb_out_q & {8{~pullup_global_disable}}; // see R13 R1
	assign pb_value_ovr_en = {
		b7_en, // see R6
		timer1_cmp_b_en, // see R7
		timer1_cmp_a_en, // see R7
		timer2_cmp_a_en, // see R8
		spi_as_slave, // see R10
		spi_as_master, // see R11
		spi_as_master, // see R12
		1'h0
	};
	assign pb_value_ovr_val = {
		b7_val,
		timer1_cmp_b_out, // see R7 R9
		timer1_cmp_a_out, // see R7 R9
		timer2_cmp_a_out, // see R8 R9
		spi_slave_out,
		spi_master_out,
		spi_sck_out,
		1'h0
	};

	assign spi_master_in = portb_sync_q[pao_pkg::PB_MISO];
	assign spi_slave_in = portb_sync_q[pao_pkg::PB_MOSI];
	assign spi_sck_in = portb_sync_q[pao_pkg::PB_SCK];
	// low level activates the slave
	assign spi_slave_sel_n = portb_sync_q[pao_pkg::PB_SS]; // see R16

	// ------------------------------------------------------------
	// pin cells
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < pao_pkg::PORT_W; gi++) begin : g_pin
			pao_pin_cell u_pa (
				.pin_direction_bit(porta_dir_q[gi]),
				.pin_output_bit(porta_out_q[gi]),
				.pullup_global_disable(pullup_global_disable), // see R1
				.pullup_ovr_en(pa_pullup_ovr_en[gi]),
				.pullup_ovr_val(pa_pullup_ovr_val[gi]),
				.dir_ovr_en(pa_dir_ovr_en[gi]),
				.dir_ovr_val(pa_dir_ovr_val[gi]),
				.value_ovr_en(pa_value_ovr_en[gi]),
				.value_ovr_val(pa_value_ovr_val[gi]),
				.pin_out(porta_pin_out[gi]),
				.pin_oe_n(porta_pin_oe_n[gi]),
				.pullup_en(porta_pullup_en[gi])
			);
			pao_pin_cell u_pb (
				.pin_direction_bit(portb_dir_q[gi]),
				.pin_output_bit(portb_out_q[gi]),
				.pullup_global_disable(pullup_global_disable), // see R1
				.pullup_ovr_en(pb_pullup_ovr_en[gi]),
				.pullup_ovr_val(pb_pullup_ovr_val[gi]),
				.dir_ovr_en(pb_dir_ovr_en[gi]),
				.dir_ovr_val(pb_dir_ovr_val[gi]),
				.value_ovr_en(pb_value_ovr_en[gi]),
				.value_ovr_val(pb_value_ovr_val[gi]),
				.pin_out(portb_pin_out[gi]),
				.pin_oe_n(portb_pin_oe_n[gi]),
				.pullup_en(portb_pullup_en[gi])
			);
		end
	endgenerate
endmodule : pao_port_ab

// [pao_port_ab_monitor.sv]
// checker for the port A/B override block
`timescale 1ns/10ps
module pao_port_ab_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] porta_pin_in,
	input wire logic [7:0] porta_pin_out,
	input wire logic [7:0] porta_pin_oe_n,
	input wire logic [7:0] porta_pullup_en,
	input wire logic [7:0] portb_pin_in,
	input wire logic [7:0] portb_pin_out,
	input wire logic [7:0] portb_pin_oe_n,
	input wire logic ext_mem_enable,
	input wire logic addr_phase_active,
	input wire logic ext_mem_wr,
	input wire logic [7:0] ext_mem_addr_lo,
	input wire logic [7:0] ext_mem_dout,
	input wire logic [7:0] ext_mem_din,
	input wire logic timer2_cmp_a_out,
	input wire logic timer2_cmp_a_en,
	input wire logic timer1_cmp_c_out,
	input wire logic timer1_cmp_c_en,
	input wire logic cmp_b7_timer1_sel,
	input wire logic spi_enable_bit,
	input wire logic spi_master_select,
	input wire logic spi_master_out,
	input wire logic spi_master_in,
	input wire logic spi_slave_in,
	input wire logic spi_sck_in,
	input wire logic spi_slave_sel_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// $past must not reach back into reset for the synchroniser checks
	logic [1:0] up_q;
	logic [1:0] up_d;
	assign up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) up_q <= 2'h0;
		else up_q <= up_d;
	end
	sequence s_addr;
		ext_mem_enable && addr_phase_active;
	endsequence
	sequence s_write;
		ext_mem_enable && ext_mem_wr && !addr_phase_active;
	endsequence
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_porta_addr_drive: assert property (s_addr |-> porta_pin_oe_n == 8'h00 &&
		porta_pin_out == ext_mem_addr_lo && porta_pullup_en == 8'h00)
		else $error("port A not driving the address");
	a_porta_data_drive: assert property (s_write |-> porta_pin_oe_n == 8'h00 &&
		porta_pin_out == ext_mem_dout && porta_pullup_en == 8'h00)
		else $error("port A not driving write data");
	a_porta_bus_release: assert property (ext_mem_enable && !addr_phase_active && !ext_mem_wr
		|-> porta_pin_oe_n == 8'hFF) else $error("port A driven outside bus phases");
	a_din_sync_delay: assert property (up_q == 2'h3 |->
		ext_mem_din == $past(porta_pin_in, 2)) else $error("data-in not the pad two cycles back");
	a_spi_in_delay: assert property (up_q == 2'h3 |->
		{spi_master_in, spi_slave_in, spi_sck_in, spi_slave_sel_n} == $past(portb_pin_in[3:0], 2))
		else $error("spi inputs not the pads two cycles back");
	a_miso_master_input: assert property (spi_enable_bit && spi_master_select
		|-> portb_pin_oe_n[3]) else $error("miso driven while master");
	a_slave_pins_input: assert property (spi_enable_bit && !spi_master_select
		|-> portb_pin_oe_n[2:0] == 3'h7) else $error("slave spi pin driven");
	a_mosi_master_value: assert property (spi_enable_bit && spi_master_select &&
		!portb_pin_oe_n[2] |-> portb_pin_out[2] == spi_master_out) else $error("mosi value wrong");
	a_cmp4_value: assert property (!portb_pin_oe_n[4] && timer2_cmp_a_en
		|-> portb_pin_out[4] == timer2_cmp_a_out) else $error("bit 4 not the timer2 waveform");
	a_cmp7_value: assert property (!portb_pin_oe_n[7] && cmp_b7_timer1_sel && timer1_cmp_c_en
		|-> portb_pin_out[7] == timer1_cmp_c_out) else $error("bit 7 not the timer1 waveform");
endmodule : pao_port_ab_monitor
bind pao_port_ab pao_port_ab_monitor pao_port_ab_monitor_i (.*);

// [pao_alt_model.sv]
// stand-in for external memory, timers and spi facing the port block
`timescale 1ns/10ps
module pao_alt_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] phase,
	output logic addr_phase_active,
	output logic ext_mem_wr,
	output logic [7:0] ext_mem_addr_lo,
	output logic [7:0] ext_mem_dout,
	output logic [4:0] cmp,
	output logic [2:0] spi_o
);
	logic [7:0] cnt_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) cnt_q <= 8'h00;
		else cnt_q <= cnt_q + 8'h01;
	end
	// address and write phases never overlap
	assign addr_phase_active = (phase == 2'h1);
	assign ext_mem_wr = (phase == 2'h2);
	assign ext_mem_addr_lo = cnt_q ^ 8'hA5;
	// data toggles every cycle so a stale value is not mistaken for a match
	assign ext_mem_dout = ~cnt_q;
	// four pwm waveforms of differing duty and a square wave on the lowest bit
	assign cmp = {cnt_q < 8'hC0, cnt_q < 8'h80, cnt_q < 8'h40, cnt_q < 8'h20, cnt_q[0]};
	assign spi_o = cnt_q[3:1];
endmodule : pao_alt_model

// [port_ab_alt_function_override_test.sv]
// self-checking bench for the port A/B override block
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module port_ab_alt_function_override_test;
	typedef struct {int s; logic [31:0] v;} pao_chk_t;
	logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, ext_mem_enable = 0, cmp_b7_timer1_sel = 0;
	logic spi_enable_bit = 0, spi_master_select = 0, pu_off = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0] htrans = 0, phase = 0;
	logic [2:0] hsize = 3'h2, spi_o;
	logic [7:0] porta_pin_in = 0, portb_pin_in = 0, da = 0, oa = 0, db = 0, ob = 0;
	logic [4:0] cen = 0, cmp;
	logic [7:0] porta_pin_out, porta_pin_oe_n, porta_pullup_en, ext_mem_din, ext_mem_addr_lo;
	logic [7:0] portb_pin_out, portb_pin_oe_n, portb_pullup_en, ext_mem_dout;
	logic hreadyout, hresp, scan_port_disable, vector_table_select, vector_change_enable;
	logic addr_phase_active, ext_mem_wr, spi_master_in, spi_slave_in, spi_sck_in, spi_slave_sel_n;
	logic timer0_cmp_a_out, timer1_cmp_c_out, timer1_cmp_b_out, timer1_cmp_a_out, timer2_cmp_a_out;
	logic timer0_cmp_a_en, timer1_cmp_c_en, timer1_cmp_b_en, timer1_cmp_a_en, timer2_cmp_a_en;
	logic spi_slave_out, spi_master_out, spi_sck_out;
	int n_mismatch = 0, samples_checked = 0;
	pao_chk_t q[$];
	string names[9] = '{"hrdata", "porta_out", "porta_oe_n", "porta_pullup", "portb_out",
		"portb_oe_n", "portb_pullup", "ext_mem_din", "mcu_side"};
	assign {timer0_cmp_a_out, timer1_cmp_c_out, timer1_cmp_b_out, timer1_cmp_a_out,
		timer2_cmp_a_out} = cmp;
	assign {timer0_cmp_a_en, timer1_cmp_c_en, timer1_cmp_b_en, timer1_cmp_a_en,
		timer2_cmp_a_en} = cen;
	assign {spi_slave_out, spi_master_out, spi_sck_out} = spi_o;
	pao_alt_model pao_alt_model_i (.*);
	pao_port_ab pao_port_ab_i (.hready(hreadyout), .*);
	always #25 clk = ~clk;
	// ------------------------------------------------------------
	// scoreboard
	// ------------------------------------------------------------
	function automatic logic [31:0] observe(input int s);
		case (s)
			0: return hrdata;
			1: return {24'h0, porta_pin_out & ~porta_pin_oe_n};
			2: return {24'h0, porta_pin_oe_n};
			3: return {24'h0, porta_pullup_en};
			4: return {24'h0, portb_pin_out & ~portb_pin_oe_n};
			5: return {24'h0, portb_pin_oe_n};
			6: return {24'h0, portb_pullup_en};
			7: return {24'h0, ext_mem_din};
			default: return {28'h0, hresp, scan_port_disable, vector_table_select,
				vector_change_enable};
		endcase
	endfunction : observe
	always @(negedge clk) begin : watch
		pao_chk_t c;
		while (q.size() > 0) begin
			c = q.pop_front();
			`CHK(names[c.s], c.v, observe(c.s))
		end
	end
	task automatic ex(input int s, input logic [7:0] v);
		q.push_back('{s, {24'h0, v}});
	endtask : ex
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			print_verdict();
		end
	endtask : wait_ready
	// single AHB transfer; on a read the expected byte is queued at the data edge
	task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= pao_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		wait_ready();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		wait_ready();
		if (!w) ex(0, d);
	endtask : ahb
	task automatic settle;
		@(posedge clk);
		#1;
	endtask : settle
	function automatic logic [7:0] pull(input logic [7:0] d, input logic [7:0] o);
		return ~d & o & {8{~pu_off}};
	endfunction : pull
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h9A4627B3));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		ahb(0, pao_pkg::OFS_MCU_CONTROL, pao_pkg::MCU_CONTROL_RESET);
		ahb(0, pao_pkg::OFS_PORTB_DIR, pao_pkg::PORT_RESET);
		ahb(0, 8'h40, 8'h00);
		ahb(1, pao_pkg::OFS_MCU_CONTROL, 8'hFF);
		ex(8, 8'h07);
		ahb(0, pao_pkg::OFS_MCU_CONTROL, pao_pkg::MCU_CONTROL_WMASK);
		for (int i = 0; i < 4; i++) begin
			da = 8'($urandom);
			oa = 8'($urandom);
			pu_off = ~i[0];
			porta_pin_in <= 8'($urandom);
			ahb(1, pao_pkg::OFS_PORTA_DIR, da);
			ahb(1, pao_pkg::OFS_PORTA_OUT, oa);
			ahb(1, pao_pkg::OFS_MCU_CONTROL, {3'h0, pu_off, 4'h0});
			settle();
			ex(1, oa & da);
			ex(2, ~da);
			ex(3, pull(da, oa));
			ex(7, porta_pin_in);
			ahb(0, pao_pkg::OFS_PORTA_PIN, porta_pin_in);
		end
		ext_mem_enable <= 1'b1;
		for (int p = 1; p < 4; p++) begin
			@(posedge clk);
			phase <= p[1:0] % 2'h3;
			settle();
			ex(2, p < 3 ? 8'h00 : 8'hFF);
			ex(3, p < 3 ? 8'h00 : pull(da, oa));
			ex(1, p == 1 ? ext_mem_addr_lo : p == 2 ? ext_mem_dout : 8'h00);
		end
		db = 8'hF0 | 8'($urandom);
		ob = 8'($urandom);
		ahb(1, pao_pkg::OFS_PORTB_DIR, db);
		ext_mem_enable <= 1'b0;
		ahb(1, pao_pkg::OFS_PORTB_OUT, ob);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			cmp_b7_timer1_sel <= i[0];
			cen <= 5'($urandom);
			settle();
			ex(5, ~db);
			ex(4, db & {(cmp_b7_timer1_sel ? cen[3] : cen[4]) ?
				(cmp_b7_timer1_sel ? cmp[3] : cmp[4]) : ob[7],
				cen[2] ? cmp[2] : ob[6], cen[1] ? cmp[1] : ob[5],
				cen[0] ? cmp[0] : ob[4], ob[3:0]});
		end
		ahb(1, pao_pkg::OFS_PORTB_DIR, 8'h0F);
		ahb(1, pao_pkg::OFS_PORTB_OUT, 8'h0F);
		spi_enable_bit <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			pu_off = (i == 2);
			ahb(1, pao_pkg::OFS_MCU_CONTROL, {3'h0, pu_off, 4'h0});
			spi_master_select <= (i == 0);
			portb_pin_in <= 8'($urandom);
			settle();
			ex(5, spi_master_select ? 8'hF8 : 8'hF7);
			ex(6, spi_master_select ? 8'h08 : {5'h0, {3{~pu_off}}});
			ex(4, spi_master_select ? {5'h0, spi_master_out, spi_sck_out, 1'b1}
				: {4'h0, spi_slave_out, 3'h0});
		end
		@(negedge clk);
		@(negedge clk);
		print_verdict();
	end
endmodule : port_ab_alt_function_override_test
